//--- src/cdw_cfg.svh
/*
  offsets, field positions and reset values of the debug sequencer, ram
  watchdog and tx cancellation block.
  assumes byte addresses on an 8-bit register port with 32-bit data.
*/
//
// Behaviour
// - store debug messages a,b,c in consecutive buffers
// - missing message restarts the debug sequence
// - dma request only after a,b,c in order
// - sequencer state readable in rx fifo status
// - clearing dma request returns sequencer to idle
// - up to 32 dedicated tx buffers plus fifo
// - keep fifo put/get indices and tx event fifo put index
// - per-buffer classic or fd format select
// - ram access loads watchdog from start value
// - ram ready reloads watchdog with start value
// - count reaching zero halts and sets flag
// - watchdog decrements on the system clock
// - live watchdog count readable in bits 15:8
// - zero start value disables watchdog, resets zero
// - write one sets cancel bit, zero ignored
// - one cancel bit per tx buffer
// - cancel bits settable only for configured buffers
// - cancel bit clears when pending bit clears
`ifndef CDW_CFG_SVH
`define CDW_CFG_SVH

`define CDW_OFS_RWD 8'h14
`define CDW_OFS_IRQ 8'h50
`define CDW_OFS_RXF1S 8'h94
`define CDW_OFS_DBG0 8'hA0
`define CDW_OFS_DBG1 8'hA4
`define CDW_OFS_DBG2 8'hA8
`define CDW_OFS_TX_BUFFER_CONFIGURATION 8'hC0
`define CDW_OFS_TXFD 8'hC4
`define CDW_OFS_TXIDX 8'hC8
`define CDW_OFS_TXBCR 8'hD4

`define CDW_RWD_WDC_LSB 0
`define CDW_RWD_WDV_LSB 8
`define CDW_IRQ_WDI_BIT 0
`define CDW_RXF1S_DMS_LSB 30
`define CDW_TXIDX_PUT_LSB 0
`define CDW_TXIDX_GET_LSB 8
`define CDW_TXIDX_EVT_LSB 16

`define CDW_RESET_WORD 32'h0000_0000
`define CDW_TAG_A 2'h1
`define CDW_TAG_B 2'h2
`define CDW_TAG_C 2'h3
`define CDW_NUM_TXBUF 6'h20

`endif

//--- src/cdw_dbg_mem.sv
/*
  four-word store for the captured debug messages, with registered read.
  assumes one write port and one read port on the same clock.
*/
`timescale 1ns/1ns
module cdw_dbg_mem (
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [1:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic [1:0] rd_addr,
  output logic [31:0] rd_data
);

  logic [31:0] mem [0:3];

  // write port
  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data leave from a register
  always_ff @(posedge clk_sys)
  begin
    rd_data <= mem[rd_addr];
  end

endmodule

//--- src/cdw_pkg.sv
/*
  types shared by the debug sequencer, ram watchdog and tx cancellation
  block. assumes nothing of its surroundings.
*/
package cdw_pkg;

  typedef enum logic [3:0] {
    SEQ_IDLE = 4'b0001,
    SEQ_GOT_A = 4'b0010,
    SEQ_GOT_B = 4'b0100,
    SEQ_DONE = 4'b1000
  } cdw_seq_t;

endpackage

//--- src/cdw_top.sv
/*
  debug message sequencer with dma request, message ram watchdog and tx
  buffer cancellation requests, with their register port.
  assumes a cpu on the register port, a filter stage that tags debug
  messages, the message ram handshake and the tx core pending bits.
*/
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
`include "cdw_cfg.svh"
module cdw_top (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic dbg_msg_valid,
  input wire logic [1:0] dbg_msg_tag,
  input wire logic [31:0] dbg_msg_data,
  output logic dbg_dma_req,
  input wire logic dbg_dma_done,
  input wire logic ram_access_start,
  input wire logic ram_ready,
  output logic ram_watchdog_timeout_flag,
  input wire logic [31:0] tx_request_pending,
  output logic [31:0] tx_cancel_request,
  output logic [31:0] tx_fd_select,
  input wire logic tx_fifo_put,
  input wire logic tx_fifo_get,
  input wire logic tx_event_put
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // enable mask of the first n dedicated buffers
  function automatic logic [31:0] buf_mask(input logic [5:0] n);
    if (n >= `CDW_NUM_TXBUF)
      buf_mask = 32'hFFFF_FFFF;
    else
      buf_mask = (32'h0000_0001 << n) - 32'h0000_0001;
  endfunction

  // address hit on a register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // debug message sequencer

  cdw_pkg::cdw_seq_t seq_r;
  cdw_pkg::cdw_seq_t seq_nxt;
  logic mem_we;
  logic [1:0] mem_waddr;
  logic [1:0] seq_code;
  logic [31:0] mem_rdata;
  logic tag_a;
  logic tag_b;
  logic tag_c;

  assign tag_a = dbg_msg_valid && (dbg_msg_tag == `CDW_TAG_A);
  assign tag_b = dbg_msg_valid && (dbg_msg_tag == `CDW_TAG_B);
  assign tag_c = dbg_msg_valid && (dbg_msg_tag == `CDW_TAG_C);

  // next state and buffer write of the sequencer
  always_comb
  begin
    seq_nxt = seq_r;
    mem_we = 1'b0;
    mem_waddr = 2'h0;
    case (seq_r)
      cdw_pkg::SEQ_IDLE:
      begin
        if (tag_a)
        begin
          seq_nxt = cdw_pkg::SEQ_GOT_A;
          mem_we = 1'b1;
          mem_waddr = 2'h0;
        end
      end
      cdw_pkg::SEQ_GOT_A:
      begin
        if (tag_a)
        begin
          mem_we = 1'b1; // fresh a starts over in the first buffer
          mem_waddr = 2'h0;
        end
        else if (tag_b)
        begin
          seq_nxt = cdw_pkg::SEQ_GOT_B;
          mem_we = 1'b1;
          mem_waddr = 2'h1;
        end
        else if (tag_c)
        begin
          seq_nxt = cdw_pkg::SEQ_IDLE;
        end
      end
      cdw_pkg::SEQ_GOT_B:
      begin
        if (tag_c)
        begin
          seq_nxt = cdw_pkg::SEQ_DONE;
          mem_we = 1'b1;
          mem_waddr = 2'h2;
        end
        else if (tag_a)
        begin
          seq_nxt = cdw_pkg::SEQ_GOT_A;
          mem_we = 1'b1;
          mem_waddr = 2'h0;
        end
        else if (tag_b)
        begin
          seq_nxt = cdw_pkg::SEQ_IDLE;
        end
      end
      cdw_pkg::SEQ_DONE:
      begin
        if (dbg_dma_done)
        begin
          seq_nxt = cdw_pkg::SEQ_IDLE;
        end
      end
      default:
      begin
        seq_nxt = cdw_pkg::SEQ_IDLE;
      end
    endcase
  end

  // sequencer state register
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      seq_r <= cdw_pkg::SEQ_IDLE;
    else
      seq_r <= seq_nxt;
  end

  // request stands for the whole done state, messages ignored there
  assign dbg_dma_req = (seq_r == cdw_pkg::SEQ_DONE);

  // status code of the sequencer
  always_comb
  begin
    case (seq_r)
      cdw_pkg::SEQ_GOT_A: seq_code = 2'h1;
      cdw_pkg::SEQ_GOT_B: seq_code = 2'h2;
      cdw_pkg::SEQ_DONE: seq_code = 2'h3;
      default: seq_code = 2'h0;
    endcase
  end

  cdw_dbg_mem u_mem (
    .clk_sys(clk_sys),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(dbg_msg_data),
    .rd_addr(reg_addr[3:2]),
    .rd_data(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // ram watchdog

  logic [7:0] wdc_r;
  logic [7:0] wd_count_r;
  logic wd_active_r;
  logic wdi_r;
  logic wd_expire;

  assign wd_expire = wd_active_r && !ram_ready && (wd_count_r == 8'h01)
    && (wdc_r != 8'h00) && !ram_access_start;

  // start value, written by software
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      wdc_r <= 8'h00;
    else if (reg_wr && hit(reg_addr, `CDW_OFS_RWD))
      wdc_r <= reg_wdata[`CDW_RWD_WDC_LSB +: 8];
  end

  // down-counter on the system clock
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      wd_count_r <= 8'h00;
      wd_active_r <= 1'b0;
    end
    else if (wdc_r == 8'h00)
    begin
      wd_active_r <= 1'b0;
    end
    else if (ram_access_start)
    begin
      wd_count_r <= wdc_r;
      wd_active_r <= 1'b1;
    end
    else if (wd_active_r && ram_ready)
    begin
      wd_count_r <= wdc_r;
      wd_active_r <= 1'b0;
    end
    else if (wd_active_r)
    begin
      wd_count_r <= wd_count_r - 8'h01;
      wd_active_r <= !wd_expire;
    end
  end

  // timeout flag, write one to clear, a new timeout wins
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      wdi_r <= 1'b0;
    else if (wd_expire)
      wdi_r <= 1'b1;
    else if (reg_wr && hit(reg_addr, `CDW_OFS_IRQ) && reg_wdata[`CDW_IRQ_WDI_BIT])
      wdi_r <= 1'b0;
  end

  assign ram_watchdog_timeout_flag = wdi_r;

  ////////////////////////////////////////////////////////////////////////
  // tx buffers: configuration, format, indices, cancellation

  logic [5:0] tx_buffer_configuration_r;
  logic [31:0] txfd_r;
  logic [31:0] cancel_r;
  logic [31:0] cancel_set;
  logic [4:0] put_r;
  logic [4:0] get_r;
  logic [4:0] evt_r;

  // buffer count and per-buffer format
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tx_buffer_configuration_r <= 6'h00;
      txfd_r <= `CDW_RESET_WORD;
    end
    else if (reg_wr && hit(reg_addr, `CDW_OFS_TX_BUFFER_CONFIGURATION))
      tx_buffer_configuration_r <= (reg_wdata[5:0] > `CDW_NUM_TXBUF) ? `CDW_NUM_TXBUF : reg_wdata[5:0];
    else if (reg_wr && hit(reg_addr, `CDW_OFS_TXFD))
      txfd_r <= reg_wdata;
  end

  assign tx_fd_select = txfd_r;

  // fifo put/get and event fifo put indices
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      put_r <= 5'h00;
      get_r <= 5'h00;
      evt_r <= 5'h00;
    end
    else
    begin
      if (tx_fifo_put)
        put_r <= put_r + 5'h01;
      if (tx_fifo_get)
        get_r <= get_r + 5'h01;
      if (tx_event_put)
        evt_r <= evt_r + 5'h01;
    end
  end

  // write ones set, only for configured buffers
  assign cancel_set = (reg_wr && hit(reg_addr, `CDW_OFS_TXBCR))
    ? (reg_wdata & buf_mask(tx_buffer_configuration_r)) : 32'h0000_0000;

  // bits fall once pending drops; a set in the same cycle wins
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      cancel_r <= `CDW_RESET_WORD;
    else
      cancel_r <= (cancel_r & tx_request_pending) | cancel_set;
  end

  assign tx_cancel_request = cancel_r;

  ////////////////////////////////////////////////////////////////////////
  // register read

  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic rd_mem_r;

  // read mux
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    case (reg_addr)
      `CDW_OFS_RWD:
      begin
        rdata_nxt[`CDW_RWD_WDC_LSB +: 8] = wdc_r;
        rdata_nxt[`CDW_RWD_WDV_LSB +: 8] = wd_count_r;
      end
      `CDW_OFS_IRQ: rdata_nxt[`CDW_IRQ_WDI_BIT] = wdi_r;
      `CDW_OFS_RXF1S: rdata_nxt[`CDW_RXF1S_DMS_LSB +: 2] = seq_code;
      `CDW_OFS_TX_BUFFER_CONFIGURATION: rdata_nxt[5:0] = tx_buffer_configuration_r;
      `CDW_OFS_TXFD: rdata_nxt = txfd_r;
      `CDW_OFS_TXIDX:
      begin
        rdata_nxt[`CDW_TXIDX_PUT_LSB +: 5] = put_r;
        rdata_nxt[`CDW_TXIDX_GET_LSB +: 5] = get_r;
        rdata_nxt[`CDW_TXIDX_EVT_LSB +: 5] = evt_r;
      end
      `CDW_OFS_TXBCR: rdata_nxt = cancel_r;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // read data registered, valid the cycle after the strobe
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rdata_r <= 32'h0000_0000;
      rd_mem_r <= 1'b0;
    end
    else
    begin
      rdata_r <= reg_rd ? rdata_nxt : 32'h0000_0000;
      rd_mem_r <= reg_rd && (hit(reg_addr, `CDW_OFS_DBG0)
        || hit(reg_addr, `CDW_OFS_DBG1) || hit(reg_addr, `CDW_OFS_DBG2));
    end
  end

  assign reg_rdata = rd_mem_r ? mem_rdata : rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence got_b_then_c;
    (seq_r == cdw_pkg::SEQ_GOT_B) && tag_c;
  endsequence

  sequence req_released;
    dbg_dma_req && dbg_dma_done;
  endsequence

  dma_after_abc_a: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(dbg_dma_req) |-> $past(seq_r == cdw_pkg::SEQ_GOT_B) && $past(tag_c))
    else $error("dma request without ordered a b c");

  store_third_a: assert property (@(posedge clk_sys) disable iff (reset)
    got_b_then_c |-> mem_we && (mem_waddr == 2'h2) ##1 dbg_dma_req)
    else $error("third debug message not stored in third buffer");

  seq_restart_a: assert property (@(posedge clk_sys) disable iff (reset)
    (seq_r == cdw_pkg::SEQ_GOT_B) && tag_b |=> (seq_code == 2'h0) && !dbg_dma_req)
    else $error("sequence not restarted on missing message");

  dma_release_a: assert property (@(posedge clk_sys) disable iff (reset)
    req_released |=> !dbg_dma_req && (seq_code == 2'h0))
    else $error("dma done did not return sequencer to idle");

  dma_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    dbg_dma_req && !dbg_dma_done |=> dbg_dma_req && $stable(seq_code))
    else $error("dma request dropped before done");

  wd_load_a: assert property (@(posedge clk_sys) disable iff (reset)
    ram_access_start && (wdc_r != 8'h00) |=> wd_active_r && (wd_count_r == $past(wdc_r)))
    else $error("watchdog not loaded on ram access");

  wd_reload_a: assert property (@(posedge clk_sys) disable iff (reset)
    wd_active_r && ram_ready && !ram_access_start && (wdc_r != 8'h00)
    |=> !wd_active_r && (wd_count_r == $past(wdc_r)))
    else $error("watchdog not reloaded on ready");

  wd_timeout_a: assert property (@(posedge clk_sys) disable iff (reset)
    wd_expire |=> (wd_count_r == 8'h00) && !wd_active_r && wdi_r ##1 (wd_count_r == 8'h00))
    else $error("watchdog timeout not flagged or not halted");

  wd_off_a: assert property (@(posedge clk_sys) disable iff (reset)
    (wdc_r == 8'h00) |=> !wd_active_r && !$rose(wdi_r))
    else $error("watchdog ran with zero start value");

  cancel_drop_a: assert property (@(posedge clk_sys) disable iff (reset)
    !(reg_wr && hit(reg_addr, `CDW_OFS_TXBCR))
    |=> (cancel_r & ~$past(tx_request_pending)) == 32'h0000_0000)
    else $error("cancel bit kept after pending cleared");

  cancel_cfg_a: assert property (@(posedge clk_sys) disable iff (reset)
    reg_wr && hit(reg_addr, `CDW_OFS_TXBCR)
    |=> (cancel_r & ~$past(cancel_r) & ~$past(buf_mask(tx_buffer_configuration_r))) == 32'h0000_0000)
    else $error("cancel bit set for unconfigured buffer");

endmodule

//--- tb/cdw_partner.sv
/*
  partner model: message ram handshake and dma engine of the debug buffers.
  assumes the block's clock and synchronous active-high reset.
*/
`timescale 1ns/1ns
module cdw_partner #(parameter int DMA_WAIT = 40) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic go,
  input wire logic [7:0] ready_wait,
  input wire logic dbg_dma_req,
  output logic ram_access_start,
  output logic ram_ready,
  output logic dbg_dma_done
);
  logic [7:0] wait_r;
  logic [7:0] dma_cnt_r;
  // ram answers ready_wait cycles after the access; zero never answers
  always_ff @(posedge clk_sys)
  begin
    ram_access_start <= go & ~reset;
    ram_ready <= ~reset & (wait_r == 8'h01);
    if (reset)
      wait_r <= 8'h00;
    else if (go)
      wait_r <= ready_wait;
    else if (wait_r != 8'h00)
      wait_r <= wait_r - 8'h01;
  end
  // dma finishes DMA_WAIT+1 cycles after the request rises, one done pulse
  always_ff @(posedge clk_sys)
  begin
    if (reset || !dbg_dma_req)
      dma_cnt_r <= 8'h00;
    else if (dma_cnt_r != 8'hFF)
      dma_cnt_r <= dma_cnt_r + 8'h01;
    dbg_dma_done <= ~reset & dbg_dma_req & (dma_cnt_r == DMA_WAIT[7:0]);
  end
endmodule

//--- tb/tb_top.sv
/*
  self-checking bench of cdw_top: register rows, debug sequence, ram
  watchdog and tx cancel requests.
  assumes cdw_partner on the ram and dma side.
*/
`timescale 1ns/1ns
module tb_top;
  logic clk_sys, reset, reg_wr, reg_rd, dbg_msg_valid, go;
  logic tx_fifo_put, tx_fifo_get, tx_event_put;
  logic dbg_dma_req, dbg_dma_done, ram_access_start, ram_ready, ram_watchdog_timeout_flag;
  logic [1:0] dbg_msg_tag;
  logic [7:0] reg_addr, ready_wait;
  logic [31:0] reg_wdata, reg_rdata, dbg_msg_data, tx_request_pending, rd_v;
  logic [31:0] tx_cancel_request, tx_fd_select;
  logic [71:0] rows [6];
  int err_count, total_checks;

  cdw_top DUT (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dbg_msg_valid(dbg_msg_valid), .dbg_msg_tag(dbg_msg_tag), .dbg_msg_data(dbg_msg_data),
    .dbg_dma_req(dbg_dma_req), .dbg_dma_done(dbg_dma_done),
    .ram_access_start(ram_access_start), .ram_ready(ram_ready),
    .ram_watchdog_timeout_flag(ram_watchdog_timeout_flag),
    .tx_request_pending(tx_request_pending), .tx_cancel_request(tx_cancel_request),
    .tx_fd_select(tx_fd_select), .tx_fifo_put(tx_fifo_put), .tx_fifo_get(tx_fifo_get),
    .tx_event_put(tx_event_put));
  cdw_partner PART (.clk_sys(clk_sys), .reset(reset), .go(go), .ready_wait(ready_wait),
    .dbg_dma_req(dbg_dma_req), .ram_access_start(ram_access_start),
    .ram_ready(ram_ready), .dbg_dma_done(dbg_dma_done));

////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // register writes and reads, one-cycle strobes
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask
  // one tagged debug message; last drops valid after it
  task automatic msg(input logic [1:0] t, input logic [31:0] d, input bit last);
    @(posedge clk_sys);
    dbg_msg_valid <= 1'b1;
    dbg_msg_tag <= t;
    dbg_msg_data <= d;
    if (last)
    begin
      @(posedge clk_sys);
      dbg_msg_valid <= 1'b0;
      #1;
    end
  endtask
  // ram access through the partner
  task automatic acc(input logic [7:0] w);
    @(posedge clk_sys);
    go <= 1'b1;
    ready_wait <= w;
    @(posedge clk_sys);
    go <= 1'b0;
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 200 && dbg_dma_req !== 1'b0; k++)
      @(posedge clk_sys);
    chk("dma req released", {31'h0000_0000, dbg_dma_req}, 32'h0000_0000);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial
  begin
    #100000;
    err_count++;
    final_report();
  end
  // main sequence
  initial
  begin
    {reset, reg_wr, reg_rd, dbg_msg_valid, go} = 5'h1F & 5'h10;
    {reg_addr, ready_wait, dbg_msg_tag, reg_wdata, dbg_msg_data} = '0;
    {tx_fifo_put, tx_fifo_get, tx_event_put} = 3'h0;
    tx_request_pending = 32'hFFFF_FFFF;
    rows[0] = {8'hC0, 32'h0000_0004, 32'h0000_0004};
    rows[1] = {8'h14, 32'h0000_FF05, 32'h0000_0005};
    rows[2] = {8'hC4, 32'h0000_00A5, 32'h0000_00A5};
    rows[3] = {8'hD4, 32'hFFFF_FFFF, 32'h0000_000F};
    rows[4] = {8'hD4, 32'h0000_0000, 32'h0000_000F};
    rows[5] = {8'h60, 32'hFFFF_FFFF, 32'h0000_0000};
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    rd(8'h14);
    chk("watchdog reset", rd_v, 32'h0000_0000);
    rd(8'hD4);
    chk("cancel reset", rd_v, 32'h0000_0000);
    foreach (rows[i])
    begin
      wr(rows[i][71:64], rows[i][63:32]);
      rd(rows[i][71:64]);
      chk("row readback", rd_v, rows[i][31:0]);
    end
    chk("fd select port", tx_fd_select, 32'h0000_00A5);
    chk("cancel port", tx_cancel_request, 32'h0000_000F);
    @(posedge clk_sys);
    tx_request_pending <= 32'hFFFF_FFFE;
    repeat (3) @(posedge clk_sys);
    #1 chk("cancel auto clear", tx_cancel_request, 32'h0000_000E);
    // three fifo puts, one get, two event puts
    @(posedge clk_sys);
    tx_fifo_put <= 1'b1;
    tx_event_put <= 1'b1;
    @(posedge clk_sys);
    tx_fifo_get <= 1'b1;
    @(posedge clk_sys);
    tx_event_put <= 1'b0;
    tx_fifo_get <= 1'b0;
    @(posedge clk_sys);
    tx_fifo_put <= 1'b0;
    rd(8'hC8);
    chk("tx indices", rd_v, 32'h0002_0103);
    // full debug sequence, tags 1,2,3 as the filters assign them
    msg(2'h1, 32'h0000_A001, 1'b0);
    msg(2'h2, 32'h0000_B002, 1'b0);
    msg(2'h3, 32'h0000_C003, 1'b1);
    chk("req after third", {31'h0000_0000, dbg_dma_req}, 32'h0000_0001);
    for (int i = 0; i < 3; i++)
    begin
      rd(8'hA0 + 8'(4 * i));
      chk("debug buffer", rd_v, 32'h0000_A001 + 32'(i * 32'h0000_1001));
    end
    rd(8'h94);
    chk("state done", {30'h0000_0000, rd_v[31:30]}, 32'h0000_0003);
    msg(2'h1, 32'h0000_9999, 1'b1);
    rd(8'hA0);
    chk("message while req", rd_v, 32'h0000_A001);
    wait_idle();
    rd(8'h94);
    chk("state idle", {30'h0000_0000, rd_v[31:30]}, 32'h0000_0000);
    msg(2'h1, 32'h0000_A011, 1'b0);
    msg(2'h3, 32'h0000_C013, 1'b1);
    chk("no req on gap", {31'h0000_0000, dbg_dma_req}, 32'h0000_0000);
    rd(8'h94);
    chk("state restarted", {30'h0000_0000, rd_v[31:30]}, 32'h0000_0000);
    msg(2'h1, 32'h0000_A021, 1'b0);
    msg(2'h2, 32'h0000_B022, 1'b0);
    msg(2'h3, 32'h0000_C023, 1'b1);
    chk("req again", {31'h0000_0000, dbg_dma_req}, 32'h0000_0001);
    wait_idle();
    // watchdog with a prompt answer, then without one, then disabled
    wr(8'h14, 32'h0000_0003);
    acc(8'h01);
    repeat (8) @(posedge clk_sys);
    #1 chk("no timeout", {31'h0000_0000, ram_watchdog_timeout_flag}, 32'h0000_0000);
    rd(8'h14);
    chk("count reloaded", rd_v, 32'h0000_0303);
    acc(8'h00);
    repeat (3) @(posedge clk_sys);
    #1 chk("flag early", {31'h0000_0000, ram_watchdog_timeout_flag}, 32'h0000_0000);
    @(posedge clk_sys);
    #1 chk("flag on zero", {31'h0000_0000, ram_watchdog_timeout_flag}, 32'h0000_0001);
    rd(8'h14);
    chk("count halted", rd_v, 32'h0000_0003);
    rd(8'h50);
    chk("flag register", rd_v, 32'h0000_0001);
    wr(8'h50, 32'h0000_0001);
    #1 chk("flag cleared", {31'h0000_0000, ram_watchdog_timeout_flag}, 32'h0000_0000);
    wr(8'h14, 32'h0000_0000);
    acc(8'h00);
    repeat (8) @(posedge clk_sys);
    #1 chk("disabled", {31'h0000_0000, ram_watchdog_timeout_flag}, 32'h0000_0000);
    rd(8'h14);
    chk("disabled count", rd_v, 32'h0000_0000);
    // reset in mid-run, with message a already taken
    msg(2'h1, 32'h0000_A031, 1'b1);
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    #1 chk("cancel after reset", tx_cancel_request, 32'h0000_0000);
    msg(2'h2, 32'h0000_B032, 1'b0);
    msg(2'h3, 32'h0000_C033, 1'b1);
    chk("no req after reset", {31'h0000_0000, dbg_dma_req}, 32'h0000_0000);
    final_report();
  end
endmodule
